// >>> verilog/tdc_top.sv
// Two 8-bit timer/event counters with a classic Wishbone register slave.
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps
module tdc_top
  import tdc_pkg::*;
#(
  parameter bit         C1_FROM_C0_OVF = 1'b0,  // Counter 1 internal clock from counter 0.
  parameter bit         PFD_ENABLE     = 1'b1,  // Divider output present on port A bit 3.
  parameter bit         PFD_FROM_C1    = 1'b0,  // Divider follows counter 1, else counter 0.
  parameter logic [7:0] PORT_A_RESET   = 8'hFF  // Port A latch after reset.
)(
  input  wire logic        clk_i,          // System clock, 10 MHz.
  input  wire logic        rst_i,          // Synchronous reset, active high.
  input  wire logic        wb_cyc_i,       // Wishbone cycle.
  input  wire logic        wb_stb_i,       // Wishbone strobe.
  input  wire logic        wb_we_i,        // Wishbone write enable.
  input  wire logic [7:0]  wb_adr_i,       // Wishbone byte address.
  input  wire logic [3:0]  wb_sel_i,       // Wishbone byte selects.
  input  wire logic [31:0] wb_dat_i,       // Wishbone write data.
  output logic      [31:0] wb_dat_o,       // Wishbone read data.
  output logic             wb_ack_o,       // Wishbone acknowledge.
  input  wire logic        c0_ext_i,       // Counter 0 external pin.
  input  wire logic        c1_ext_i,       // Counter 1 external pin.
  output logic             c0_irq_o,       // Counter 0 interrupt request.
  output logic             c1_irq_o,       // Counter 1 interrupt request.
  output logic             wake_o,         // Wake-up pulse on any overflow.
  output logic             port_a_bit3_o   // Port A bit 3 pin level.
);

  // Bus access decode.
  logic        req;       // A new request is on the bus.
  logic        wr_lane;   // Write with the low byte lane selected.
  logic [7:0]  wdat;      // Low byte of the write data.
  logic [7:0]  rd_nxt;    // Read data for the current address.
  logic        ack_r;     // Acknowledge register.
  logic [31:0] rdat_r;    // Read data register.

  // Per-channel strobes, arrays index the channel.
  logic [1:0]  wr_data;   // Write to a data register.
  logic [1:0]  wr_ctrl;   // Write to a control register.
  logic [1:0]  rd_data;   // Read of a data register.
  logic        wr_interrupt_control_0;  // Write to interrupt control 0.
  logic        wr_interrupt_control_1;  // Write to interrupt control 1.
  logic        wr_porta;  // Write to the port A latch.

  // Counter state.
  logic [7:0]    count_r   [2];  // Live counts.
  logic [7:0]    preload_r [2];  // Preload values.
  tdc_mode_t     mode_r    [2];  // Operating modes.
  logic [1:0]    run_r;          // Run bits.
  logic [1:0]    edge_r;         // Edge select bits.
  logic [2:0]    psc_r;          // Counter 0 prescaler field.
  tdc_pw_state_t pw_r      [2];  // Pulse-width sequence states.

  // Per-channel clocking terms.
  logic [1:0] rise;      // Rising edges.
  logic [1:0] fall;      // Falling edges.
  logic [1:0] act_edge;  // Active edge as chosen by the edge bit.
  logic [1:0] ret_edge;  // Opposite edge that ends a measurement.
  logic [1:0] int_tick;  // Internal clock enables.
  logic [1:0] inc;       // Count advances this cycle.
  logic [1:0] ovf;       // Count rolls over this cycle.
  logic [1:0] pw_end;    // Measurement completes this cycle.
  logic       psc_tick;  // Prescaled clock for counter 0.
  logic       div4_tick; // Quarter-rate clock for counter 1.

  // Interrupt control and port state.
  logic       c0_flag_r;  // Counter 0 overflow flag.
  logic       c1_flag_r;  // Counter 1 overflow flag.
  logic       c0_en_r;    // Counter 0 interrupt enable.
  logic       c1_en_r;    // Counter 1 interrupt enable.
  logic [7:0] porta_r;    // Port A latch.
  logic       pfd_tog_r;  // Divider output toggle.
  logic       c0_irq_r;   // Counter 0 request register.
  logic       c1_irq_r;   // Counter 1 request register.
  logic       wake_r;     // Wake-up register.
  logic       pa3_r;      // Port A bit 3 pin register.

  // Internal clock sources.
  // Selectable power-of-two prescaler.
  tdc_prescaler #(.W (TDC_PSC_WIDTH)) u_psc (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .sel_i  (psc_r),
    .tick_o (psc_tick),
    .div4_o (div4_tick)
  );

  // Pin synchronisers for both external inputs.
  tdc_pin_sync u_sync0 (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (c0_ext_i),
    .level_o (),
    .rise_o  (rise[0]),
    .fall_o  (fall[0])
  );

  tdc_pin_sync u_sync1 (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (c1_ext_i),
    .level_o (),
    .rise_o  (rise[1]),
    .fall_o  (fall[1])
  );

  // Decode the bus request; one access is taken per ack.
  always_comb
  begin
    req      = wb_cyc_i & wb_stb_i & ~ack_r;
    wr_lane  = req & wb_we_i & wb_sel_i[0];
    wdat     = wb_dat_i[7:0];
    wr_data  = {wr_lane & (wb_adr_i == tdc_byte_addr(TDC_IDX_C1_DATA)),
                wr_lane & (wb_adr_i == tdc_byte_addr(TDC_IDX_C0_DATA))};
    wr_ctrl  = {wr_lane & (wb_adr_i == tdc_byte_addr(TDC_IDX_C1_CTRL)),
                wr_lane & (wb_adr_i == tdc_byte_addr(TDC_IDX_C0_CTRL))};
    rd_data  = {req & ~wb_we_i & (wb_adr_i == tdc_byte_addr(TDC_IDX_C1_DATA)),
                req & ~wb_we_i & (wb_adr_i == tdc_byte_addr(TDC_IDX_C0_DATA))};
    wr_interrupt_control_0 = wr_lane & (wb_adr_i == tdc_byte_addr(TDC_IDX_INTERRUPT_CONTROL_0));
    wr_interrupt_control_1 = wr_lane & (wb_adr_i == tdc_byte_addr(TDC_IDX_INTERRUPT_CONTROL_1));
    wr_porta = wr_lane & (wb_adr_i == tdc_byte_addr(TDC_IDX_PORT_A));
  end

  // Read multiplexer; unmapped addresses read as zero.
  always_comb
  begin
    rd_nxt = 8'h00;
    if (wb_adr_i == tdc_byte_addr(TDC_IDX_C0_DATA))
      rd_nxt = count_r[0];
    else if (wb_adr_i == tdc_byte_addr(TDC_IDX_C1_DATA))
      rd_nxt = count_r[1];
    else if (wb_adr_i == tdc_byte_addr(TDC_IDX_C0_CTRL))
      rd_nxt = {mode_r[0], 1'b0, run_r[0], edge_r[0], psc_r} & TDC_C0_CTRL_MASK;
    else if (wb_adr_i == tdc_byte_addr(TDC_IDX_C1_CTRL))
      rd_nxt = {mode_r[1], 1'b0, run_r[1], edge_r[1], 3'b000} & TDC_C1_CTRL_MASK;
    else if (wb_adr_i == tdc_byte_addr(TDC_IDX_INTERRUPT_CONTROL_0))
      rd_nxt = 8'(({7'h00, c0_flag_r} << TDC_INTERRUPT_CONTROL_0_FLAG) | ({7'h00, c0_en_r} << TDC_INTERRUPT_CONTROL_0_EN));
    else if (wb_adr_i == tdc_byte_addr(TDC_IDX_INTERRUPT_CONTROL_1))
      rd_nxt = 8'(({7'h00, c1_flag_r} << TDC_INTERRUPT_CONTROL_1_FLAG) | ({7'h00, c1_en_r} << TDC_INTERRUPT_CONTROL_1_EN));
    else if (wb_adr_i == tdc_byte_addr(TDC_IDX_PORT_A))
      rd_nxt = porta_r;
  end

  // Answer every request one cycle later and drop ack the cycle after.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r <= req;
      if (req & ~wb_we_i)
        rdat_r <= {24'h00_0000, rd_nxt};
    end
  end

  // Internal clock choice for each channel.
  always_comb
  begin
    int_tick[0] = psc_tick;
    // Counter 1 source is a build option.
    int_tick[1] = C1_FROM_C0_OVF ? ovf[0] : div4_tick;
  end

  // The two counters share one structure.
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_ch
    // Advance and overflow decisions.
    always_comb
    begin
      // Edge bit picks the active transition.
      act_edge[ch] = edge_r[ch] ? fall[ch] : rise[ch];
      ret_edge[ch] = edge_r[ch] ? rise[ch] : fall[ch];
      inc[ch]      = 1'b0;
      // Counting only while running; frozen during a read.
      if (run_r[ch] & ~rd_data[ch])
      begin
        unique case (mode_r[ch])
          TDC_MODE_EVENT:  inc[ch] = act_edge[ch];
          TDC_MODE_TIMER:  inc[ch] = int_tick[ch];
          // Pulse mode times with the internal clock.
          TDC_MODE_PULSE:  inc[ch] = (pw_r[ch] == TDC_PW_MEAS) & int_tick[ch];
          TDC_MODE_UNUSED: inc[ch] = 1'b0;
        endcase
      end
      ovf[ch]    = inc[ch] & (count_r[ch] == TDC_COUNT_MAX);
      pw_end[ch] = (mode_r[ch] == TDC_MODE_PULSE) & run_r[ch] &
                   (pw_r[ch] == TDC_PW_MEAS) & ret_edge[ch];
    end

    // Count and preload registers.
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        count_r[ch]   <= TDC_DATA_RESET;
        preload_r[ch] <= TDC_DATA_RESET;
      end
      else
      begin
        // Write reaches the count only when stopped.
        if (wr_data[ch])
          preload_r[ch] <= wdat;
        // Roll reloads from preload; in pulse mode too.
        if (wr_data[ch] & ~run_r[ch])
          count_r[ch] <= wdat;
        else if (ovf[ch])
          count_r[ch] <= preload_r[ch];
        else if (inc[ch])
          count_r[ch] <= count_r[ch] + 8'h01;
      end
    end

    // Control fields; software writes, pulse mode may clear run.
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        mode_r[ch] <= tdc_mode_t'(TDC_CTRL_RESET[TDC_CTRL_MODE_HI:TDC_CTRL_MODE_LO]);
        run_r[ch]  <= TDC_CTRL_RESET[TDC_CTRL_RUN];
        edge_r[ch] <= TDC_CTRL_RESET[TDC_CTRL_EDGE];
      end
      else if (wr_ctrl[ch])
      begin
        mode_r[ch] <= tdc_mode_t'(wdat[TDC_CTRL_MODE_HI:TDC_CTRL_MODE_LO]);
        run_r[ch]  <= wdat[TDC_CTRL_RUN];
        edge_r[ch] <= wdat[TDC_CTRL_EDGE];
      end
      // Run clears when the measurement ends.
      else if (pw_end[ch])
        run_r[ch] <= 1'b0;
    end

    // Pulse-width sequence: wait for edge, measure, then hold.
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        pw_r[ch] <= TDC_PW_WAIT;
      // Leaving pulse mode or stopping abandons a measurement.
      else if ((mode_r[ch] != TDC_MODE_PULSE) | ~run_r[ch])
        pw_r[ch] <= (pw_r[ch] == TDC_PW_MEAS) ? TDC_PW_DONE : pw_r[ch];
      else
      begin
        unique case (pw_r[ch])
          TDC_PW_WAIT: pw_r[ch] <= act_edge[ch] ? TDC_PW_MEAS : TDC_PW_WAIT;
          TDC_PW_MEAS: pw_r[ch] <= ret_edge[ch] ? TDC_PW_DONE : TDC_PW_MEAS;
          // Result held until run is set again.
          TDC_PW_DONE: pw_r[ch] <= TDC_PW_WAIT;
          default:     pw_r[ch] <= TDC_PW_WAIT;
        endcase
      end
    end
  end

  // Prescaler field of counter 0.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      psc_r <= TDC_CTRL_RESET[TDC_CTRL_PSC_HI:0];
    else if (wr_ctrl[0])
      psc_r <= wdat[TDC_CTRL_PSC_HI:0];
  end

  // Overflow flags; a new overflow beats a software clear.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      c0_flag_r <= 1'b0;
      c1_flag_r <= 1'b0;
      c0_en_r   <= 1'b0;
      c1_en_r   <= 1'b0;
    end
    else
    begin
      c0_flag_r <= ovf[0] | (wr_interrupt_control_0 ? wdat[TDC_INTERRUPT_CONTROL_0_FLAG] : c0_flag_r);
      c1_flag_r <= ovf[1] | (wr_interrupt_control_1 ? wdat[TDC_INTERRUPT_CONTROL_1_FLAG] : c1_flag_r);
      if (wr_interrupt_control_0)
        c0_en_r <= wdat[TDC_INTERRUPT_CONTROL_0_EN];
      if (wr_interrupt_control_1)
        c1_en_r <= wdat[TDC_INTERRUPT_CONTROL_1_EN];
    end
  end

  // Interrupt requests and wake-up pulse.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      c0_irq_r <= 1'b0;
      c1_irq_r <= 1'b0;
      wake_r   <= 1'b0;
    end
    else
    begin
      c0_irq_r <= c0_flag_r & c0_en_r;
      c1_irq_r <= c1_flag_r & c1_en_r;
      wake_r   <= ovf[0] | ovf[1];
    end
  end

  // Port A latch, divider toggle and bit 3 pin.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      porta_r   <= PORT_A_RESET;
      pfd_tog_r <= 1'b0;
      pa3_r     <= 1'b0;
    end
    else
    begin
      if (wr_porta)
        porta_r <= wdat;
      if (PFD_FROM_C1 ? ovf[1] : ovf[0])
        pfd_tog_r <= ~pfd_tog_r;
      // Latch bit 3 gates the divider onto the pin.
      pa3_r <= PFD_ENABLE ? (porta_r[TDC_PA_PFD_BIT] & pfd_tog_r) : porta_r[TDC_PA_PFD_BIT];
    end
  end

  // Outputs straight from registers.
  assign wb_ack_o      = ack_r;
  assign wb_dat_o      = rdat_r;
  assign c0_irq_o      = c0_irq_r;
  assign c1_irq_o      = c1_irq_r;
  assign wake_o        = wake_r;
  assign port_a_bit3_o = pa3_r;

endmodule

// >>> verilog/tdc_pkg.sv
// Shared constants and types for the dual timer/event counter block.
package tdc_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] TDC_IDX_C0_DATA = 8'h0D;  // Counter 0 count and preload.
  localparam logic [7:0] TDC_IDX_C0_CTRL = 8'h0E;  // Counter 0 control.
  localparam logic [7:0] TDC_IDX_C1_DATA = 8'h10;  // Counter 1 count and preload.
  localparam logic [7:0] TDC_IDX_C1_CTRL = 8'h11;  // Counter 1 control.
  localparam logic [7:0] TDC_IDX_INTERRUPT_CONTROL_0   = 8'h0B;  // Interrupt control 0.
  localparam logic [7:0] TDC_IDX_INTERRUPT_CONTROL_1   = 8'h1E;  // Interrupt control 1.
  localparam logic [7:0] TDC_IDX_PORT_A  = 8'h12;  // Port A output latch.

  // Control register field positions.
  localparam int TDC_CTRL_MODE_HI = 7;  // Top bit of the mode field.
  localparam int TDC_CTRL_MODE_LO = 6;  // Bottom bit of the mode field.
  localparam int TDC_CTRL_RUN     = 4;  // Run bit.
  localparam int TDC_CTRL_EDGE    = 3;  // Active edge select bit.
  localparam int TDC_CTRL_PSC_HI  = 2;  // Top bit of the prescaler field.

  // Interrupt control field positions.
  localparam int TDC_INTERRUPT_CONTROL_0_FLAG = 6;  // Counter 0 overflow flag.
  localparam int TDC_INTERRUPT_CONTROL_0_EN   = 2;  // Counter 0 interrupt enable.
  localparam int TDC_INTERRUPT_CONTROL_1_FLAG = 4;  // Counter 1 overflow flag.
  localparam int TDC_INTERRUPT_CONTROL_1_EN   = 0;  // Counter 1 interrupt enable.
  localparam int TDC_PA_PFD_BIT = 3;  // Port A bit that carries the divider output.

  // Readable bits of each control register; unused bits read as zero.
  localparam logic [7:0] TDC_C0_CTRL_MASK = 8'hDF;  // Bit 5 unused.
  localparam logic [7:0] TDC_C1_CTRL_MASK = 8'hD8;  // Bits 5 and 2..0 unused.

  // Reset values.
  localparam logic [7:0] TDC_CTRL_RESET  = 8'h08;  // Off, falling edge, mode unused.
  localparam logic [7:0] TDC_DATA_RESET  = 8'h00;  // Count and preload.
  localparam logic [7:0] TDC_COUNT_MAX   = 8'hFF;  // Last value before the roll.

  // Timing figures.
  localparam int TDC_PSC_WIDTH = 7;  // Prescaler stages, division up to 128.
  localparam int TDC_C1_DIV    = 4;  // Fixed divider for counter 1 internal clock.

  // Operating modes held in control bits 7:6.
  typedef enum logic [1:0] {
    TDC_MODE_UNUSED = 2'b00,
    TDC_MODE_EVENT  = 2'b01,
    TDC_MODE_TIMER  = 2'b10,
    TDC_MODE_PULSE  = 2'b11
  } tdc_mode_t;

  // Pulse-width measurement sequence, one-hot.
  typedef enum logic [2:0] {
    TDC_PW_WAIT = 3'b001,
    TDC_PW_MEAS = 3'b010,
    TDC_PW_DONE = 3'b100
  } tdc_pw_state_t;

  // Byte address of a register index on the bus.
  function automatic logic [7:0] tdc_byte_addr(input logic [7:0] idx);
    tdc_byte_addr = {idx[5:0], 2'b00};
  endfunction

endpackage

// >>> verilog/tdc_prescaler.sv
// Free-running divider that gives one-cycle enable pulses for the internal clocks.
`timescale 1ns/1ps
module tdc_prescaler
  import tdc_pkg::*;
#(
  parameter int W = TDC_PSC_WIDTH  // Number of prescaler stages.
)(
  input  wire logic       clk_i,   // System clock.
  input  wire logic       rst_i,   // Synchronous reset, active high.
  input  wire logic [2:0] sel_i,   // Power of two to divide by.
  output logic            tick_o,  // Selected prescaled enable pulse.
  output logic            div4_o   // Enable pulse at one quarter rate.
);

  logic [W-1:0] cnt_r;  // Divider stages.
  logic [W-1:0] mask;   // Low stages that must all be ones.

  // The divider runs on from reset and is never stopped.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_r <= '0;
    end
    else
    begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // A tick fires when the chosen number of low stages are all ones.
  always_comb
  begin
    mask   = W'((1 << sel_i) - 1);
    tick_o = ((cnt_r & mask) == mask);
    div4_o = (cnt_r[1:0] == 2'(TDC_C1_DIV - 1));
  end

endmodule

// >>> verilog/tdc_pin_sync.sv
// Two-stage synchroniser with edge detection for one external counter pin.
`timescale 1ns/1ps
module tdc_pin_sync (
  input  wire logic clk_i,    // System clock.
  input  wire logic rst_i,    // Synchronous reset, active high.
  input  wire logic pin_i,    // Raw pin from outside the clock domain.
  output logic      level_o,  // Synchronised pin level.
  output logic      rise_o,   // One-cycle pulse on a low-to-high change.
  output logic      fall_o    // One-cycle pulse on a high-to-low change.
);

  logic sync1_r;  // First stage, read only by the second.
  logic sync2_r;  // Second stage, safe to use.
  logic prev_r;   // Previous synchronised level.

  // Bring the pin into the clock domain and keep one older sample.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end
    else
    begin
      sync1_r <= pin_i;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // Edges are found between the second stage and the older sample.
  always_comb
  begin
    level_o = sync2_r;
    rise_o  = sync2_r & ~prev_r;
    fall_o  = ~sync2_r & prev_r;
  end

endmodule

// >>> testbench/tdc_top_asserts.sv
// Checker of bus timing, spare bits and quiet outputs of the timer block.
`timescale 1ns/1ps
module tdc_top_asserts (
  input wire logic        clk_i,         // System clock.
  input wire logic        rst_i,         // Synchronous reset.
  input wire logic        wb_cyc_i,      // Bus cycle.
  input wire logic        wb_stb_i,      // Bus strobe.
  input wire logic        wb_we_i,       // Bus write.
  input wire logic [7:0]  wb_adr_i,      // Bus address.
  input wire logic [31:0] wb_dat_o,      // Read data.
  input wire logic        wb_ack_o,      // Acknowledge.
  input wire logic        c0_irq_o,      // Counter 0 request.
  input wire logic        c1_irq_o,      // Counter 1 request.
  input wire logic        wake_o,        // Wake-up pulse.
  input wire logic        port_a_bit3_o  // Divider pin.
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic rd;  // A read is taken at this edge.
  assign rd = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
  chk_ack_one_shot: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  chk_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  chk_read_data_holds: assert property (!rd |=> $stable(wb_dat_o))
    else $error("read data moved without a read");
  chk_unmapped_zero: assert property (rd && wb_adr_i == 8'h00 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_c0_spare_bit: assert property (rd && wb_adr_i == 8'h38 |=> !wb_dat_o[5])
    else $error("counter 0 spare bit set");
  chk_c1_spare_bits: assert property (rd && wb_adr_i == 8'h44 |=>
    (wb_dat_o[7:0] & 8'h27) == 8'h00)
    else $error("counter 1 spare bits set");
  chk_reset_quiet: assert property (disable iff (1'b0)
    rst_i |=> !c0_irq_o && !c1_irq_o && !wake_o && !port_a_bit3_o)
    else $error("outputs active after reset");
endmodule
bind tdc_top tdc_top_asserts i_tdc_top_asserts (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .c0_irq_o, .c1_irq_o, .wake_o, .port_a_bit3_o);

// >>> testbench/tdc_pulse_src.sv
// Pulse burst source standing in for a counter's external pin.
`timescale 1ns/1ps
module tdc_pulse_src (
  input  wire logic       clk_i,   // System clock.
  input  wire logic       rst_i,   // Reset, pin goes low.
  input  wire logic       go_i,    // Start a burst.
  input  wire logic       tail_i,  // End the burst high.
  input  wire logic [3:0] num_i,   // Whole pulses in a burst.
  input  wire logic [3:0] wid_i,   // Cycles per half period.
  output logic            pin_o,   // Pin level.
  output logic            busy_o   // Burst in progress.
);
  logic [4:0] half_r;  // Half periods still to run.
  logic [3:0] cnt_r;   // Cycles left in this half.
  assign busy_o = (half_r != 5'h00);
  // external events
  // The pin starts low and flips at each half end, so an odd count ends high.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || go_i)
    begin
      pin_o  <= 1'b0;
      half_r <= rst_i ? 5'h00 : {num_i, tail_i};
      cnt_r  <= wid_i;
    end
    else if (busy_o)
    begin
      if (cnt_r == 4'h1)
      begin
        pin_o  <= ~pin_o;
        half_r <= half_r - 5'h01;
        cnt_r  <= wid_i;
      end
      else
        cnt_r <= cnt_r - 4'h1;
    end
  end
endmodule

// >>> testbench/tb_tdc_top.sv
// Self-checking bench for the dual timer/event counter.
`timescale 1ns/1ps
module tb_tdc_top;
  logic        clk, rst, cyc, stb, we;  // Clock, reset, bus controls.
  logic [7:0]  adr, q, v, n, w, ac, ad;  // Address and scratch values.
  logic [3:0]  sel, num, wid;           // Selects and burst shape.
  logic [31:0] wdat, rdat;              // Bus data.
  logic        ack, irq0, irq1, wake, pa3, pa3_q;  // Design outputs.
  logic [1:0]  go, tl, pin, bsy;        // Pulse source controls.
  int          mismatches, n_tests, wakes, tog, k, t0;  // Counters.
  tdc_top i_tdc_top (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .c0_ext_i(pin[0]), .c1_ext_i(pin[1]), .c0_irq_o(irq0),
    .c1_irq_o(irq1), .wake_o(wake), .port_a_bit3_o(pa3));
  tdc_pulse_src i_tdc_pulse_src (.clk_i(clk), .rst_i(rst), .go_i(go[0]), .tail_i(tl[0]),
    .num_i(num), .wid_i(wid), .pin_o(pin[0]), .busy_o(bsy[0]));
  tdc_pulse_src i_tdc_pulse_src_b (.clk_i(clk), .rst_i(rst), .go_i(go[1]), .tail_i(tl[1]),
    .num_i(num), .wid_i(wid), .pin_o(pin[1]), .busy_o(bsy[1]));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Counts wake pulses and divider pin changes.
  always @(posedge clk)
  begin
    pa3_q <= pa3;
    if (wake === 1'b1) wakes <= wakes + 1;
    if (pa3 !== pa3_q) tog <= tog + 1;
  end
  task automatic end_of_test();
    $display("Counts: %0d mismatches in %0d comparisons", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic guard(input int i);
    if (i >= 900)
    begin
      mismatches++;
      $display("ERROR %0t wait ran out", $time);
      end_of_test();
    end
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e)
    begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  function automatic logic [7:0] inw(input logic [7:0] x, lo, hi);
    return {7'h00, x >= lo && x <= hi};
  endfunction
  // One classic cycle; holds until ack is sampled, then one idle cycle.
  task automatic bus(input logic wr_, input logic [7:0] a, d, output logic [7:0] r);
    int i;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr_;
    adr <= a;
    wdat <= {24'h000000, d};
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (ack !== 1'b1 && i < 900);
    guard(i);
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [7:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] r);
    bus(1'b0, a, 8'h00, r);
  endtask
  // Starts a burst on one pin and waits for its end.
  task automatic burst(input int c, input logic [3:0] nn, ww, input logic t);
    int i;
    num <= nn;
    wid <= ww;
    tl[c] <= t;
    go[c] <= 1'b1;
    @(posedge clk);
    go[c] <= 1'b0;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (bsy[c] !== 1'b0 && i < 900);
    guard(i);
  endtask
  initial
  begin
    {cyc, stb, we, adr, wdat, go, tl, num} = '0;
    {sel, wid, rst} = {4'hF, 4'h1, 1'b1};
    {mismatches, n_tests, wakes, tog} = '0;
    void'($urandom(32'h3DE7));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h38, q); chk(q, 8'h08);
    rd(8'h44, q); chk(q, 8'h08);
    wr(8'h00, 8'h5A); rd(8'h00, q); chk(q, 8'h00);
    wr(8'h38, 8'h2F); rd(8'h38, q); chk(q, 8'h0F);
    wr(8'h44, 8'h2F); rd(8'h44, q); chk(q, 8'h08);
    wr(8'h38, 8'h90); wr(8'h38, 8'h80); wr(8'h44, 8'h90); wr(8'h44, 8'h80);
    v = 8'($urandom);
    wr(8'h38, 8'h00); wr(8'h34, v); rd(8'h34, q); chk(q, v);
    t0 = wakes;
    wr(8'h38, 8'h10); repeat (40) @(posedge clk); rd(8'h34, q); chk(q, v);
    chk(wakes - t0, 8'h00);
    for (int p = 0; p < 8; p++)
    begin
      wr(8'h38, 8'h80); wr(8'h34, 8'h00); wr(8'h38, 8'h90 | p[2:0]);
      repeat (64 << p) @(posedge clk);
      wr(8'h38, 8'h80); rd(8'h34, q); chk(inw(q, 62, 69), 8'h01);
    end
    // A data read freezes the running count for its taking cycle only.
    wr(8'h38, 8'h90); rd(8'h34, q); rd(8'h34, v); wr(8'h38, 8'h80);
    chk(v - q, 8'h02);
    wr(8'h34, 8'hF0); wr(8'h2C, 8'h04);
    {t0, k} = {tog, 32'h0};
    wr(8'h38, 8'h90);
    while (irq0 !== 1'b1 && k < 900)
    begin
      @(posedge clk);
      k++;
    end
    guard(k);
    rd(8'h2C, q); chk(q & 8'h44, 8'h44);
    rd(8'h34, q); chk(inw(q, 8'hF0, 8'hFA), 8'h01);
    wr(8'h2C, 8'h00); repeat (40) @(posedge clk); chk(irq0, 1'b0);
    rd(8'h2C, q); chk(q & 8'h44, 8'h40);
    chk(inw(wakes - 0, 3, 255), 8'h01);
    chk(inw(tog - t0, 2, 9), 8'h01);
    wr(8'h48, 8'h00); repeat (3) @(posedge clk);
    t0 = tog; repeat (40) @(posedge clk); chk(tog - t0, 8'h00);
    wr(8'h38, 8'h80); wr(8'h48, 8'hFF);
    wr(8'h44, 8'h80); wr(8'h40, 8'h00); wr(8'h44, 8'h90); wr(8'h40, 8'hC0);
    repeat (200) @(posedge clk);
    wr(8'h44, 8'h80); rd(8'h40, q); chk(inw(q, 48, 57), 8'h01);
    repeat (30) @(posedge clk); rd(8'h40, v); chk(v, q);
    for (int c = 0; c < 2; c++)
      for (int e = 0; e < 2; e++)
      begin
        {n, w} = {8'd3 + 8'($urandom % 10), 8'd2 + 8'($urandom % 6)};
        {ac, ad} = c ? {8'h44, 8'h40} : {8'h38, 8'h34};
        wr(ac, 8'h40 | 8'(e << 3)); wr(ad, 8'h00); wr(ac, 8'h50 | 8'(e << 3));
        burst(c, n[3:0], w[3:0], 1'b1); repeat (6) @(posedge clk);
        wr(ac, 8'h40); rd(ad, q); chk(q, e ? n : n + 8'h01);
        burst(c, 4'h0, 4'h1, 1'b0);
      end
    w = 8'd4 + 8'($urandom % 10);
    wr(8'h38, 8'hC0); wr(8'h34, 8'h00); wr(8'h38, 8'hD0);
    burst(0, 4'h1, w[3:0], 1'b0); repeat (6) @(posedge clk);
    rd(8'h38, q); chk(q, 8'hC0);
    rd(8'h34, v); chk(inw(v, w - 8'h02, w + 8'h01), 8'h01);
    burst(0, 4'h1, w[3:0], 1'b0); rd(8'h34, q); chk(q, v);
    wr(8'h34, 8'hF8); wr(8'h2C, 8'h04); wr(8'h38, 8'hD0);
    burst(0, 4'h1, 4'hF, 1'b0); repeat (6) @(posedge clk);
    chk(irq0, 1'b1);
    rd(8'h34, q); chk(inw(q, 8'hF9, 8'hFF), 8'h01);
    end_of_test();
  end
endmodule
